// [insulation_seq_pkg.sv]
/*
  Shared constants for the insulation test sequencer and judge: clock rate,
  line cycle periods, register offsets, field positions, reset values and
  the sequencer state type.
  Assumes a single 25 MHz system clock shared by every module that uses it.
*/
package insulation_seq_pkg;

  // System clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 40;
  // One line cycle at 50 Hz and at 60 Hz, in microseconds.
  localparam int LINE_50HZ_US  = 20000;
  localparam int LINE_60HZ_US  = 16700;
  // Line cycle lengths in system clock cycles, derived from the times above.
  localparam int LINE_50HZ_CYC = LINE_50HZ_US * 1000 / CLK_PERIOD_NS;
  localparam int LINE_60HZ_CYC = LINE_60HZ_US * 1000 / CLK_PERIOD_NS;
  // Width of the line cycle divider counter.
  localparam int DIV_W         = 20;

  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CONFIG   = 8'h04;
  localparam logic [7:0] OFS_SAMPLE   = 8'h08;
  localparam logic [7:0] OFS_HOLDOFF  = 8'h0c;
  localparam logic [7:0] OFS_DURATION = 8'h10;
  localparam logic [7:0] OFS_CMPDLY   = 8'h14;
  localparam logic [7:0] OFS_UPPER    = 8'h18;
  localparam logic [7:0] OFS_LOWER    = 8'h1c;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_VALUE    = 8'h24;

  // Control register bits (write-only pulses).
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT = 1;

  // Configuration register fields.
  localparam int CFG_W         = 9;
  localparam int CFG_MAINS_60  = 0;
  localparam int CFG_MODE_LO   = 1;
  localparam int CFG_DLY_AUTO  = 3;
  localparam int CFG_UPPER_EN  = 4;
  localparam int CFG_LOWER_EN  = 5;
  localparam int CFG_COMP_EN   = 6;
  localparam int CFG_MFD_EN    = 7;
  localparam int CFG_BUZZ_EN   = 8;
  localparam logic [8:0] CFG_RESET = 9'h178;

  // Test modes.
  localparam logic [1:0] MODE_CONTINUOUS_TEST = 2'h0;
  localparam logic [1:0] MODE_PASS_STOP       = 2'h1;
  localparam logic [1:0] MODE_FAIL_STOP       = 2'h2;

  // Line cycle setting limits and reset value.
  localparam logic [6:0] LC_MIN = 7'h01;
  localparam logic [6:0] LC_MAX = 7'h64;
  // Limit values are held in thousandths of a megohm.
  localparam int         LIM_W     = 24;
  localparam logic [23:0] LIM_MAX  = 24'h989298;
  localparam int         TIME_W    = 16;

  // Sequencer states, Gray coded along idle, holdoff, measure.
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_HOLDOFF = 2'b01,
    ST_MEASURE = 2'b11
  } seq_state_t;

endpackage

// [line_cycle_tick.sv]
/*
  Line cycle divider: emits a one-cycle enable pulse once per mains cycle.
  Assumes the 25 MHz system clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module line_cycle_tick #(
  parameter int CYC_50 = insulation_seq_pkg::LINE_50HZ_CYC,
  parameter int CYC_60 = insulation_seq_pkg::LINE_60HZ_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic mains_60_i,
  input  wire logic restart_i,
  output logic      tick_o
);

  // Cycles elapsed within the current line cycle.
  logic [insulation_seq_pkg::DIV_W-1:0] count_q;
  // Terminal count for the selected mains frequency.
  logic [insulation_seq_pkg::DIV_W-1:0] last_w;

  assign last_w = mains_60_i ? insulation_seq_pkg::DIV_W'(CYC_60 - 1)
                             : insulation_seq_pkg::DIV_W'(CYC_50 - 1);

  // Restart aligns the first tick to one full line cycle after test start.
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i || restart_i)
    begin
      count_q <= '0;
      tick_o  <= 1'b0;
    end
    else if (count_q >= last_w)
    begin
      count_q <= '0;
      tick_o  <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 1'b1;
      tick_o  <= 1'b0;
    end
  end

endmodule // line_cycle_tick

// [limit_judge.sv]
/*
  Combinational limit comparison of one resistance sample.
  Assumes inputs are stable in the cycle in which the caller samples outputs.
*/
`timescale 1ns/1ps
module limit_judge (
  input  wire logic [23:0] value_i,
  input  wire logic [23:0] upper_i,
  input  wire logic [23:0] lower_i,
  input  wire logic        upper_en_i,
  input  wire logic        lower_en_i,
  input  wire logic        over_i,
  input  wire logic        under_i,
  input  wire logic        mfd_en_i,
  input  wire logic [7:0]  mfd_count_i,
  output logic             upper_fail_o,
  output logic             pass_o,
  output logic             lower_fail_o
);

  // Judgment is impossible on a flagged sample or a micro-failure hit.
  logic both_fail;
  // Each side fails only if enabled; a disabled side counts as met.
  logic up_bad;
  logic lo_bad;

  assign both_fail    = over_i || under_i
                        || (mfd_en_i && mfd_count_i != 8'h00);
  assign up_bad       = upper_en_i && !(value_i < upper_i);
  assign lo_bad       = lower_en_i && !(value_i > lower_i);
  assign upper_fail_o = both_fail || up_bad;
  assign lower_fail_o = both_fail || lo_bad;
  assign pass_o       = !both_fail && !up_bad && !lo_bad;

endmodule // limit_judge

// [insulation_test_sequencer_judge.sv]
/*
  Insulation test sequencer and judge: line cycle timing of holdoff, sampling,
  duration and comparator delay, and limit judgment with result indicators.
  Assumes a 25 MHz clock, a register master that never waits, a front end
  on the same clock, and an asynchronous voltage-stable pin.
*/
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module insulation_test_sequencer_judge #(
  parameter int CYC_50 = insulation_seq_pkg::LINE_50HZ_CYC,
  parameter int CYC_60 = insulation_seq_pkg::LINE_60HZ_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        meas_valid_i,
  input  wire logic [23:0] meas_value_i,
  input  wire logic        meas_over_i,
  input  wire logic        meas_under_i,
  input  wire logic [7:0]  micro_failure_count_i,
  input  wire logic        voltage_stable_i,
  output logic             hv_enable_o,
  output logic             sample_o,
  output logic             delay_active_o,
  output logic             upper_fail_o,
  output logic             pass_o,
  output logic             lower_fail_o,
  output logic             buzzer_o,
  output logic             test_done_o
);

  // Clamp a written line cycle setting into the legal range.
  function automatic logic [6:0] clamp_lc(input logic [31:0] v);
    return (v < 32'(insulation_seq_pkg::LC_MIN)) ? insulation_seq_pkg::LC_MIN
         : (v > 32'(insulation_seq_pkg::LC_MAX)) ? insulation_seq_pkg::LC_MAX : v[6:0];
  endfunction
  // Clamp a written limit to the top of the settable range.
  function automatic logic [23:0] clamp_lim(input logic [31:0] v);
    return (v > 32'(insulation_seq_pkg::LIM_MAX)) ? insulation_seq_pkg::LIM_MAX : v[23:0];
  endfunction

  // Configuration and setting registers.
  logic [8:0]                        cfg_q;
  logic [6:0]                        interval_set_q;
  logic [6:0]                        holdoff_set_q;
  logic [15:0]                       duration_set_q;
  logic [15:0]                       cmpdly_set_q;
  logic [23:0]                       upper_q;
  logic [23:0]                       lower_q;
  // Sequencer state and timing counters, all in line cycles.
  insulation_seq_pkg::seq_state_t    state_q;
  logic [15:0]                       elapsed_q;
  logic [6:0]                        interval_cnt_q;
  logic                              delay_q;
  // Result flags and captured sample.
  logic                              result_valid_q;
  logic                              no_value_q;
  logic [23:0]                       value_q;
  // Voltage-stable pin synchroniser.
  logic                              vstable_meta_q;
  logic                              vstable_q;
  // Decoded strobes and judge outputs.
  logic                              start_w;
  logic                              abort_w;
  logic                              tick_w;
  logic                              judge_now;
  logic                              j_upper;
  logic                              j_pass;
  logic                              j_lower;
  logic                              busy_w;
  logic                              dur_end_w;
  logic                              stop_end_w;
  logic                              end_w;
  logic [1:0]                        mode_w;
  assign busy_w  = (state_q != insulation_seq_pkg::ST_IDLE);
  assign mode_w  = cfg_q[insulation_seq_pkg::CFG_MODE_LO +: 2];
  assign start_w = reg_wr_i && reg_addr_i == insulation_seq_pkg::OFS_CTRL
                   && reg_wdata_i[insulation_seq_pkg::CTRL_START] && !busy_w;
  assign abort_w = reg_wr_i && reg_addr_i == insulation_seq_pkg::OFS_CTRL
                   && reg_wdata_i[insulation_seq_pkg::CTRL_ABORT] && busy_w;
  // A sample is judged only once the comparator delay is over.
  assign judge_now = state_q == insulation_seq_pkg::ST_MEASURE && meas_valid_i
                     && !delay_q
                     && cfg_q[insulation_seq_pkg::CFG_COMP_EN];
  // Duration zero means the timer is off; the test then runs until aborted or ended by a stop mode.
  assign dur_end_w  = tick_w && duration_set_q != 16'h0000
                      && elapsed_q + 16'h0001 >= duration_set_q;
  assign stop_end_w = judge_now
                      && ((mode_w == insulation_seq_pkg::MODE_PASS_STOP && j_pass)
                       || (mode_w == insulation_seq_pkg::MODE_FAIL_STOP && !j_pass));
  assign end_w      = busy_w && (dur_end_w || stop_end_w || abort_w);
  // Line cycle divider, restarted at test start for exact alignment.
  line_cycle_tick #(.CYC_50 (CYC_50), .CYC_60 (CYC_60)) u_tick (
    .sys_clk_i  (sys_clk_i),
    .reset_n_i  (reset_n_i),
    .mains_60_i (cfg_q[insulation_seq_pkg::CFG_MAINS_60]),
    .restart_i  (start_w),
    .tick_o     (tick_w)
  );

  // Limit comparison of the sample currently offered by the front end.
  limit_judge u_judge (
    .value_i      (meas_value_i),
    .upper_i      (upper_q),
    .lower_i      (lower_q),
    .upper_en_i   (cfg_q[insulation_seq_pkg::CFG_UPPER_EN]),
    .lower_en_i   (cfg_q[insulation_seq_pkg::CFG_LOWER_EN]),
    .over_i       (meas_over_i),
    .under_i      (meas_under_i),
    .mfd_en_i     (cfg_q[insulation_seq_pkg::CFG_MFD_EN]),
    .mfd_count_i  (micro_failure_count_i),
    .upper_fail_o (j_upper),
    .pass_o       (j_pass),
    .lower_fail_o (j_lower)
  );

  // Two flip-flops on the pin; only the second one is looked at.
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      {vstable_q, vstable_meta_q} <= 2'b00;
    else
      {vstable_q, vstable_meta_q} <= {vstable_meta_q, voltage_stable_i};
  end
  // Setting registers. Settings may change mid-test and take effect at once.
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      cfg_q          <= insulation_seq_pkg::CFG_RESET;
      interval_set_q <= insulation_seq_pkg::LC_MIN;
      holdoff_set_q  <= insulation_seq_pkg::LC_MIN;
      duration_set_q <= 16'h0000;
      cmpdly_set_q   <= 16'h0000;
      upper_q        <= 24'h000000;
      lower_q        <= 24'h000000;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        insulation_seq_pkg::OFS_CONFIG:   cfg_q          <= reg_wdata_i[8:0];
        insulation_seq_pkg::OFS_SAMPLE:   interval_set_q <= clamp_lc(reg_wdata_i);
        insulation_seq_pkg::OFS_HOLDOFF:  holdoff_set_q  <= clamp_lc(reg_wdata_i);
        insulation_seq_pkg::OFS_DURATION: duration_set_q <= reg_wdata_i[15:0];
        insulation_seq_pkg::OFS_CMPDLY:   cmpdly_set_q   <= reg_wdata_i[15:0];
        insulation_seq_pkg::OFS_UPPER:    upper_q        <= clamp_lim(reg_wdata_i);
        insulation_seq_pkg::OFS_LOWER:    lower_q        <= clamp_lim(reg_wdata_i);
        default: ; // Writes elsewhere, control included, store nothing here.
      endcase
    end
  end
  // Read port: data stands in the cycle after the strobe only.
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i || !reg_rd_i)
      reg_rdata_o <= 32'h00000000;
    else
    begin
      case (reg_addr_i)
        insulation_seq_pkg::OFS_CONFIG:   reg_rdata_o <= {23'h000000, cfg_q};
        insulation_seq_pkg::OFS_SAMPLE:   reg_rdata_o <= {25'h0000000, interval_set_q};
        insulation_seq_pkg::OFS_HOLDOFF:  reg_rdata_o <= {25'h0000000, holdoff_set_q};
        insulation_seq_pkg::OFS_DURATION: reg_rdata_o <= {16'h0000, duration_set_q};
        insulation_seq_pkg::OFS_CMPDLY:   reg_rdata_o <= {16'h0000, cmpdly_set_q};
        insulation_seq_pkg::OFS_UPPER:    reg_rdata_o <= {8'h00, upper_q};
        insulation_seq_pkg::OFS_LOWER:    reg_rdata_o <= {8'h00, lower_q};
        insulation_seq_pkg::OFS_STATUS:
          reg_rdata_o <= {21'h000000, no_value_q, result_valid_q, test_done_o,
                          buzzer_o, lower_fail_o, pass_o, upper_fail_o,
                          delay_q, state_q, busy_w};
        insulation_seq_pkg::OFS_VALUE:    reg_rdata_o <= {8'h00, value_q};
        default:                          reg_rdata_o <= 32'h00000000;
      endcase
    end
  end
  // Sequencer: idle, then holdoff, then measuring until the test ends.
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      state_q <= insulation_seq_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        insulation_seq_pkg::ST_IDLE:
          if (start_w)
            state_q <= insulation_seq_pkg::ST_HOLDOFF;
        insulation_seq_pkg::ST_HOLDOFF:
          if (end_w)
            state_q <= insulation_seq_pkg::ST_IDLE;
          else if (tick_w && elapsed_q + 16'h0001 >= 16'(holdoff_set_q))
            state_q <= insulation_seq_pkg::ST_MEASURE;
        insulation_seq_pkg::ST_MEASURE:
          if (end_w)
            state_q <= insulation_seq_pkg::ST_IDLE;
        default:
          state_q <= insulation_seq_pkg::ST_IDLE;
      endcase
    end
  end
  // Line cycles since start; it saturates so a long untimed test is safe.
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i || start_w)
      elapsed_q <= 16'h0000;
    else if (busy_w && tick_w && elapsed_q != 16'hffff)
      elapsed_q <= elapsed_q + 16'h0001;
  end
  // Sampling interval: one sample request per configured interval.
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i || state_q != insulation_seq_pkg::ST_MEASURE || end_w)
    begin
      interval_cnt_q <= 7'h00;
      sample_o       <= 1'b0;
    end
    else if (tick_w && interval_cnt_q + 7'h01 >= interval_set_q)
    begin
      interval_cnt_q <= 7'h00;
      sample_o       <= 1'b1;
    end
    else
    begin
      if (tick_w)
        interval_cnt_q <= interval_cnt_q + 7'h01;
      sample_o <= 1'b0;
    end
  end
  // Comparator delay: auto waits for the settled voltage, manual for time.
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      delay_q <= 1'b0;
    else if (start_w)
      delay_q <= 1'b1;
    else if (!busy_w)
      delay_q <= 1'b0;
    else if (cfg_q[insulation_seq_pkg::CFG_DLY_AUTO])
    begin
      if (vstable_q)
        delay_q <= 1'b0;
    end
    else if (elapsed_q >= cmpdly_set_q)
      delay_q <= 1'b0;
  end
  // Test voltage enable and end-of-test pulse.
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      hv_enable_o <= 1'b0;
      test_done_o <= 1'b0;
    end
    else
    begin
      hv_enable_o <= start_w || (hv_enable_o && !end_w);
      test_done_o <= end_w;
    end
  end
  // Judgment results, held from one judged sample to the next.
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i || start_w)
    begin
      upper_fail_o   <= 1'b0;
      pass_o         <= 1'b0;
      lower_fail_o   <= 1'b0;
      buzzer_o       <= 1'b0;
      result_valid_q <= 1'b0;
      value_q        <= 24'h000000;
    end
    else if (judge_now)
    begin
      upper_fail_o   <= j_upper;
      pass_o         <= j_pass;
      lower_fail_o   <= j_lower;
      buzzer_o       <= !j_pass && cfg_q[insulation_seq_pkg::CFG_BUZZ_EN];
      result_valid_q <= 1'b1;
      value_q        <= meas_value_i;
    end
  end
  // A test that ends before any sample is flagged as having no value.
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i || start_w)
      no_value_q <= 1'b0;
    else if (end_w && !result_valid_q && !judge_now)
      no_value_q <= 1'b1;
  end

  assign delay_active_o = delay_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // A judged pass in pass-stop mode.
  sequence s_pass_stop;
    judge_now && j_pass && mode_w == insulation_seq_pkg::MODE_PASS_STOP;
  endsequence
  // A judged fail in fail-stop mode.
  sequence s_fail_stop;
    judge_now && !j_pass && mode_w == insulation_seq_pkg::MODE_FAIL_STOP;
  endsequence

  chk_holdoff_quiet: assert property (
    state_q == insulation_seq_pkg::ST_HOLDOFF |=> !sample_o)
    else $error("sample requested during measure holdoff");
  chk_interval_range: assert property (
    interval_set_q >= 7'h01 && interval_set_q <= 7'h64)
    else $error("sampling interval out of range");
  chk_delay_blocks: assert property (
    delay_q && !result_valid_q |=> !result_valid_q)
    else $error("judgment made during comparator delay");
  chk_auto_release: assert property (
    busy_w && !start_w && !abort_w && cfg_q[insulation_seq_pkg::CFG_DLY_AUTO]
    && vstable_q |=> !delay_active_o)
    else $error("auto delay not released on stable voltage");
  chk_upper_fail: assert property (
    judge_now && cfg_q[insulation_seq_pkg::CFG_UPPER_EN]
    && meas_value_i > upper_q |=> upper_fail_o && !pass_o)
    else $error("upper fail not flagged");
  chk_lower_fail: assert property (
    judge_now && cfg_q[insulation_seq_pkg::CFG_LOWER_EN]
    && meas_value_i < lower_q |=> lower_fail_o && !pass_o)
    else $error("lower fail not flagged");
  chk_pass_exclusive: assert property (
    pass_o |-> !upper_fail_o && !lower_fail_o)
    else $error("pass shown together with a fail");
  chk_flag_both: assert property (
    judge_now && (meas_over_i || meas_under_i) |=> upper_fail_o && lower_fail_o)
    else $error("flagged sample not judged as both fail");
  chk_stop_modes: assert property (
    s_pass_stop or s_fail_stop |=> !hv_enable_o && test_done_o
    ##1 !test_done_o)
    else $error("stop mode did not end the test");
  chk_done_drops_hv: assert property (
    test_done_o |-> !hv_enable_o && $past(hv_enable_o))
    else $error("end pulse without voltage removal");

endmodule // insulation_test_sequencer_judge

// [front_end_model.sv]
/*
  Behavioural measurement front end: answers each sample request with one
  measurement pulse after a chosen latency.
  Assumes the sequencer's clock and a one-cycle sample request.
*/
`timescale 1ns/1ps
module front_end_model (
  input  wire logic        sys_clk_i,
  input  wire logic        sample_i,
  input  wire logic [1:0]  lat_i,
  input  wire logic [23:0] value_i,
  input  wire logic        over_i,
  input  wire logic        under_i,
  output logic             valid_o = 1'b0,
  output logic [23:0]      value_o = 24'h0,
  output logic             over_o  = 1'b0,
  output logic             under_o = 1'b0
);
  int wait_q = -1; // Cycles left before answering; -1 means nothing pending.

  // Outside the valid pulse the value lines carry the inverse, so a design
  // that samples them off the strobe judges the wrong number.
  always @(posedge sys_clk_i)
  begin
    valid_o <= 1'b0;
    over_o  <= 1'b0;
    under_o <= 1'b0;
    value_o <= ~value_i;
    if (wait_q == 0)
    begin
      valid_o <= 1'b1;
      value_o <= value_i;
      over_o  <= over_i;
      under_o <= under_i;
    end
    if (sample_i)
      wait_q <= lat_i;
    else
      wait_q <= (wait_q >= 0) ? wait_q - 1 : -1;
  end
endmodule // front_end_model

// [testbench.sv]
/*
  Self-checking bench of the insulation sequencer and judge.
  Assumes front_end_model answers sample requests and short line cycles.
*/
`timescale 1ns/1ps
module testbench;
  localparam int C50 = 8; // Shortened line cycle at 50 Hz keeps runs short.
  localparam int C60 = 7; // Shortened line cycle at 60 Hz.
  logic        sys_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        meas_valid_i, meas_over_i, meas_under_i;
  logic [23:0] meas_value_i;
  logic [7:0]  micro_failure_count_i = 8'h00;
  logic        voltage_stable_i = 1'b0;
  logic        hv_enable_o, sample_o, delay_active_o, upper_fail_o;
  logic        pass_o, lower_fail_o, buzzer_o, test_done_o;
  logic [1:0]  lat = 2'h0;  // Front end latency, varied per test.
  logic [23:0] val = 24'h0; // Value the front end reports.
  logic        ov = 1'b0;
  logic        un = 1'b0;
  logic [31:0] rd;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          n;  // Cycles from the start edge to the end pulse.
  int          ns; // Cycles from the start edge to the first sample request.

  always #20 sys_clk_i = ~sys_clk_i;

  insulation_test_sequencer_judge #(.CYC_50(C50), .CYC_60(C60)) dut (
    .sys_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .meas_valid_i, .meas_value_i, .meas_over_i, .meas_under_i,
    .micro_failure_count_i, .voltage_stable_i, .hv_enable_o, .sample_o,
    .delay_active_o, .upper_fail_o, .pass_o, .lower_fail_o, .buzzer_o,
    .test_done_o
  );
  front_end_model fe (
    .sys_clk_i, .sample_i(sample_o), .lat_i(lat), .value_i(val), .over_i(ov),
    .under_i(un), .valid_o(meas_valid_i), .value_o(meas_value_i),
    .over_o(meas_over_i), .under_o(meas_under_i)
  );

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hung handshake is cut short here and counted as a mismatch.
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One strobe cycle, then an idle one, so no strobe is driven twice at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  // Read data is taken once settled, in the cycle after the strobe edge.
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd = reg_rdata_o;
    chk(rd, exp);
    @(posedge sys_clk_i);
  endtask

  // Returns one cycle after the start edge.
  task automatic go(input logic [31:0] cfg);
    wr(insulation_seq_pkg::OFS_CONFIG, cfg);
    wr(insulation_seq_pkg::OFS_CTRL, 32'h1);
  endtask

  task automatic wait_end();
    n = 1;
    ns = 0;
    #1;
    chk(hv_enable_o, 1'b1);
    while (test_done_o !== 1'b1 && n < 500)
    begin
      if (sample_o === 1'b1 && ns == 0) ns = n;
      @(posedge sys_clk_i);
      n++;
      #1;
    end
    chk(hv_enable_o, 1'b0);
    @(posedge sys_clk_i);
  endtask

  // Runs that a stop mode ends pass ed as 0: they must end before the timed end.
  task automatic run(input logic [31:0] cfg, input logic [23:0] v, input logic [2:0] f,
                     input logic [2:0] res, input int es, input int ed);
    val <= v;
    ov <= f[1];
    un <= f[0];
    micro_failure_count_i <= {7'h00, f[2]};
    lat <= lat + 2'h1;
    go(cfg);
    wait_end();
    chk(ns, es);
    if (ed > 0) chk(n, ed);
    else chk(n < 25, 1);
    chk({upper_fail_o, pass_o, lower_fail_o}, res);
    chk(buzzer_o, cfg[8] & (res[2] | res[0]));
  endtask

  // The delay flag is watched with the voltage unsettled, then settled.
  task automatic dly(input logic [31:0] cfg, input logic e);
    voltage_stable_i <= 1'b0;
    go(cfg);
    repeat (11) @(posedge sys_clk_i);
    #1 chk(delay_active_o, 1'b1);
    repeat (10) @(posedge sys_clk_i);
    #1 chk(delay_active_o, e);
    if (e) chk({upper_fail_o, pass_o, lower_fail_o}, 3'h0);
    @(posedge sys_clk_i);
    voltage_stable_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1 chk(delay_active_o, 1'b0);
    wait_end();
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rdc(insulation_seq_pkg::OFS_CONFIG, 32'h178);
    rdc(insulation_seq_pkg::OFS_SAMPLE, 32'h1);
    rdc(8'h3c, 32'h0);
    wr(insulation_seq_pkg::OFS_SAMPLE, 32'h0);
    rdc(insulation_seq_pkg::OFS_SAMPLE, 32'h1);
    wr(insulation_seq_pkg::OFS_HOLDOFF, 32'h7f);
    rdc(insulation_seq_pkg::OFS_HOLDOFF, 32'h64);
    wr(insulation_seq_pkg::OFS_UPPER, 32'hffffff);
    rdc(insulation_seq_pkg::OFS_UPPER, {8'h00, insulation_seq_pkg::LIM_MAX});
    $display("test registers done");
    wr(insulation_seq_pkg::OFS_HOLDOFF, 32'h1);
    wr(insulation_seq_pkg::OFS_DURATION, 32'h3);
    wr(insulation_seq_pkg::OFS_UPPER, 32'h7d0);
    wr(insulation_seq_pkg::OFS_LOWER, 32'h3e8);
    run(32'h170, 24'hbb8, 3'h0, 3'h4, 17, 25);
    run(32'h170, 24'h5dc, 3'h0, 3'h2, 17, 25);
    run(32'h170, 24'h1f4, 3'h0, 3'h1, 17, 25);
    run(32'h170, 24'h7d0, 3'h0, 3'h4, 17, 25);
    run(32'h170, 24'h5dc, 3'h2, 3'h5, 17, 25);
    run(32'h170, 24'h5dc, 3'h1, 3'h5, 17, 25);
    run(32'h1f0, 24'h5dc, 3'h4, 3'h5, 17, 25);
    run(32'h160, 24'hbb8, 3'h0, 3'h2, 17, 25);
    run(32'h150, 24'h1f4, 3'h0, 3'h2, 17, 25);
    run(32'h130, 24'hbb8, 3'h0, 3'h0, 17, 25);
    run(32'h070, 24'hbb8, 3'h0, 3'h4, 17, 25);
    run(32'h172, 24'h5dc, 3'h0, 3'h2, 17, 0);
    run(32'h174, 24'hbb8, 3'h0, 3'h4, 17, 0);
    run(32'h174, 24'h5dc, 3'h0, 3'h2, 17, 25);
    $display("test judgment done");
    wr(insulation_seq_pkg::OFS_DURATION, 32'h6);
    wr(insulation_seq_pkg::OFS_CMPDLY, 32'h2);
    dly(32'h170, 1'b0);
    dly(32'h178, 1'b1);
    $display("test comparator delay done");
    wr(insulation_seq_pkg::OFS_CMPDLY, 32'h0);
    wr(insulation_seq_pkg::OFS_DURATION, 32'h1);
    wr(insulation_seq_pkg::OFS_SAMPLE, 32'h3);
    run(32'h170, 24'h5dc, 3'h0, 3'h0, 0, C50 + 1);
    rdc(insulation_seq_pkg::OFS_STATUS, 32'h400);
    wr(insulation_seq_pkg::OFS_HOLDOFF, 32'h2);
    wr(insulation_seq_pkg::OFS_DURATION, 32'h6);
    run(32'h171, 24'h5dc, 3'h0, 3'h2, 5 * C60 + 1, 6 * C60 + 1);
    $display("test timing done");
    rdc(insulation_seq_pkg::OFS_VALUE, 32'h5dc);
    wr(insulation_seq_pkg::OFS_DURATION, 32'h0);
    go(32'h170);
    repeat (30) @(posedge sys_clk_i);
    rdc(insulation_seq_pkg::OFS_STATUS, 32'h7);
    wr(insulation_seq_pkg::OFS_CTRL, 32'h2);
    rdc(insulation_seq_pkg::OFS_STATUS, 32'h400);
    $display("test abort done");
    wrap_up();
  end
endmodule // testbench
